/* File: rtl/loop_cfg_pkg.sv */
package loop_cfg_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [7:0] LOOP1_DAMPING_OFFSET = 8'h6B;
    localparam logic [7:0] LOOP2_GAIN_OFFSET    = 8'h6C;

    localparam logic [7:0] LOOP1_DAMPING_RESET  = 8'h14;
    localparam logic [7:0] LOOP2_GAIN_RESET     = 8'hC2;

    // Writable bits; a write clears all others, but the LOOP2 reset value sets bit 6
    localparam logic [7:0] LOOP1_DAMPING_MASK   = 8'h77;
    localparam logic [7:0] LOOP2_GAIN_MASK      = 8'h87;

    localparam int unsigned DAMP_CODE_LSB   = 0;
    localparam int unsigned LOWRATE_GAIN_LSB = 4;
    localparam int unsigned DIG_GAIN_LSB    = 0;
    localparam int unsigned AUTO_GAIN_BIT   = 7;

    // Damping factor in tenths
    localparam logic [7:0] DAMP_1P2 = 8'h0C;
    localparam logic [7:0] DAMP_2P5 = 8'h19;
    localparam logic [7:0] DAMP_5   = 8'h32;
    localparam logic [7:0] DAMP_10  = 8'h64;
    localparam logic [7:0] DAMP_20  = 8'hC8;
    localparam logic [7:0] DAMP_NONE = 8'h00;

    typedef enum logic [1:0]
    {
        BW_18HZ = 2'h0,
        BW_35HZ = 2'h1,
        BW_70HZ = 2'h2
    } loop_bw_t;

    typedef struct packed
    {
        logic              wr_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wr_data;
    } reg_req_t;

    typedef struct packed
    {
        logic       enable;
        logic [2:0] gain;
    } pd_gain_t;

endpackage

/* File: rtl/loop_damping_gain_config.sv */
`timescale 1ns/10ps
`default_nettype none

module loop_damping_gain_config
(
    input  wire logic                   i_ref_clk,               // Clock
    input  wire logic                   i_rst_b,                 // Reset, low
    input  wire loop_cfg_pkg::reg_req_t i_req,                   // Access
    output logic [7:0]                  o_rd_data,               // Read data
    input  wire loop_cfg_pkg::loop_bw_t i_primary_bw,            // Bandwidth
    input  wire logic                   i_primary_lowrate,       // Low ref
    input  wire logic                   i_secondary_digital_fb,  // Digital
    input  wire logic [2:0]             i_secondary_analog_gain, // Analog
    output logic [7:0]                  o_primary_damping,       // Tenths
    output logic                        o_primary_damping_ok,    // Defined
    output logic [2:0]             o_primary_analog_lowrate_gain, // Gain
    output loop_cfg_pkg::pd_gain_t      o_secondary_pd_gain      // Gain
);

    // Register storage
    logic [7:0]             loop1_q;
    logic [7:0]             loop1_d;
    logic [7:0]             loop2_q;
    logic [7:0]             loop2_d;

    // Decoded outputs
    logic [7:0]             damp_q;
    logic [7:0]             damp_d;
    logic                   damp_ok_q;
    logic                   damp_ok_d;
    loop_cfg_pkg::pd_gain_t gain_q;
    loop_cfg_pkg::pd_gain_t gain_d;

    // Field views and strobes
    logic [2:0]             damp_code;
    logic                   auto_on;
    logic [2:0]             dig_gain;
    logic                   wr_loop1;
    logic                   wr_loop2;
    logic                   sel_loop1;
    logic                   sel_loop2;

    // Field slices below assume byte-wide registers and addresses
    if (loop_cfg_pkg::DATA_W != 8 || loop_cfg_pkg::ADDR_W != 8)
    begin : g_width_check
        $error("register bus must be eight bits wide");
    end

    // Address match, shared by the write and the read path
    function automatic logic reg_hit
    (
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        return addr == offset;
    endfunction

    // Bandwidth codes outside the three loop settings are reserved
    function automatic logic bw_defined
    (
        input loop_cfg_pkg::loop_bw_t bw
    );
        return bw == loop_cfg_pkg::BW_18HZ ||
               bw == loop_cfg_pkg::BW_35HZ ||
               bw == loop_cfg_pkg::BW_70HZ;
    endfunction

    // Damping factor in tenths for one code at one bandwidth
    function automatic logic [7:0] damping_factor
    (
        input loop_cfg_pkg::loop_bw_t bw,
        input logic [2:0]             code
    );
        logic [7:0] factor;
        factor = loop_cfg_pkg::DAMP_NONE;
        case (code)
            3'h1: factor = loop_cfg_pkg::DAMP_1P2;
            3'h2: factor = loop_cfg_pkg::DAMP_2P5;
            3'h3: factor = loop_cfg_pkg::DAMP_5;
            3'h4:
            begin
                if (bw == loop_cfg_pkg::BW_18HZ)
                    factor = loop_cfg_pkg::DAMP_5;
                else
                    factor = loop_cfg_pkg::DAMP_10;
            end
            3'h5:
            begin
                if (bw == loop_cfg_pkg::BW_18HZ)
                    factor = loop_cfg_pkg::DAMP_5;
                else if (bw == loop_cfg_pkg::BW_35HZ)
                    factor = loop_cfg_pkg::DAMP_10;
                else
                    factor = loop_cfg_pkg::DAMP_20;
            end
            default:
            begin
                factor = loop_cfg_pkg::DAMP_NONE;
            end
        endcase
        return factor;
    endfunction

    assign damp_code = loop1_q[loop_cfg_pkg::DAMP_CODE_LSB +: 3];
    assign auto_on   = loop2_q[loop_cfg_pkg::AUTO_GAIN_BIT];
    assign dig_gain  = loop2_q[loop_cfg_pkg::DIG_GAIN_LSB +: 3];

    assign sel_loop1 = reg_hit(i_req.addr, loop_cfg_pkg::LOOP1_DAMPING_OFFSET);
    assign sel_loop2 = reg_hit(i_req.addr, loop_cfg_pkg::LOOP2_GAIN_OFFSET);
    assign wr_loop1  = i_req.wr_en && sel_loop1;
    assign wr_loop2  = i_req.wr_en && sel_loop2;

    always_comb
    begin
        loop1_d = loop1_q;
        loop2_d = loop2_q;
        if (wr_loop1)
        begin
            loop1_d = i_req.wr_data & loop_cfg_pkg::LOOP1_DAMPING_MASK;
        end
        if (wr_loop2)
        begin
            loop2_d = i_req.wr_data & loop_cfg_pkg::LOOP2_GAIN_MASK;
        end
    end

    // Read is a plain mux so a write shows on the next cycle
    always_comb
    begin
        o_rd_data = 8'h00;
        if (sel_loop1)
        begin
            o_rd_data = loop1_q;
        end
        else if (sel_loop2)
        begin
            o_rd_data = loop2_q;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            loop1_q <= loop_cfg_pkg::LOOP1_DAMPING_RESET;
            loop2_q <= loop_cfg_pkg::LOOP2_GAIN_RESET;
        end
        else
        begin
            loop1_q <= loop1_d;
            loop2_q <= loop2_d;
        end
    end

    always_comb
    begin
        damp_ok_d = 1'b0;
        damp_d    = loop_cfg_pkg::DAMP_NONE;
        // Reserved bandwidth gives no factor rather than a guess
        if (bw_defined(i_primary_bw))
        begin
            damp_d    = damping_factor(i_primary_bw, damp_code);
            damp_ok_d = (damp_code >= 3'h1) && (damp_code <= 3'h5);
        end
    end

    always_comb
    begin
        gain_d.enable = auto_on;
        if (!auto_on || i_secondary_digital_fb)
        begin
            gain_d.gain = dig_gain;
        end
        else
        begin
            gain_d.gain = i_secondary_analog_gain;
        end
    end

    // Decoded outputs lag the register by one cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            damp_q    <= loop_cfg_pkg::DAMP_NONE;
            damp_ok_q <= 1'b0;
            gain_q    <= '0;
        end
        else
        begin
            damp_q    <= damp_d;
            damp_ok_q <= damp_ok_d;
            gain_q    <= gain_d;
        end
    end

    assign o_primary_damping    = damp_q;
    assign o_primary_damping_ok = damp_ok_q;

    // low-rate analog gain field
    // Rate qualifier is applied by the loop, not here
    assign o_primary_analog_lowrate_gain =
        loop1_q[loop_cfg_pkg::LOWRATE_GAIN_LSB +: 3];

    assign o_secondary_pd_gain  = gain_q;

endmodule

`default_nettype wire

/* File: bench/damp_ref.svh */
// Expected damping in tenths; bandwidth 3 and codes 0, 6, 7 give 0
function automatic logic [7:0] damp(input logic [1:0] b, input logic [2:0] c);
    if (b == 2'h3)
        return 8'h00;
    case (c)
        3'h1: return 8'h0C;
        3'h2: return 8'h19;
        3'h3: return 8'h32;
        3'h4: return (b == 2'h0) ? 8'h32 : 8'h64;
        3'h5: return (b == 2'h0) ? 8'h32 : (b == 2'h1) ? 8'h64 : 8'hC8;
        default: return 8'h00;
    endcase
endfunction

/* File: bench/loop_cfg_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module loop_cfg_monitor
(
    input wire logic                   i_ref_clk,                     // Clk
    input wire logic                   i_rst_b,                       // Rst
    input wire loop_cfg_pkg::reg_req_t i_req,                         // Req
    input wire logic [7:0]             o_rd_data,                     // Rd
    input wire loop_cfg_pkg::loop_bw_t i_primary_bw,                  // Bw
    input wire logic                   i_secondary_digital_fb,        // Mode
    input wire logic [2:0]             i_secondary_analog_gain,       // Gain
    input wire logic [7:0]             o_primary_damping,             // Damp
    input wire logic                   o_primary_damping_ok,          // Ok
    input wire logic [2:0]             o_primary_analog_lowrate_gain, // Low
    input wire loop_cfg_pkg::pd_gain_t o_secondary_pd_gain            // Pd
);
`include "damp_ref.svh"
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // Register field only sampled while no write can move it
    sequence s_rd(logic [7:0] a);
        i_req.addr == a && !i_req.wr_en;
    endsequence
    a_damp_map: assert property (s_rd(8'h6B) |=>
        o_primary_damping == damp($past(i_primary_bw), $past(o_rd_data[2:0]))
        && o_primary_damping_ok == (o_primary_damping != 8'h00))
        else $error("damping map");
    a_wr_damp_mask: assert property (i_req.wr_en && i_req.addr == 8'h6B
        ##1 i_req.addr == 8'h6B |-> o_rd_data == ($past(i_req.wr_data) & 8'h77))
        else $error("damping write");
    a_wr_gain_mask: assert property (i_req.wr_en && i_req.addr == 8'h6C
        ##1 i_req.addr == 8'h6C |-> o_rd_data == ($past(i_req.wr_data) & 8'h87))
        else $error("gain write");
    a_unmapped_zero: assert property (i_req.addr != 8'h6B
        && i_req.addr != 8'h6C |-> o_rd_data == 8'h00) else $error("unmapped");
    a_lowrate_field: assert property (i_req.addr == 8'h6B |->
        o_primary_analog_lowrate_gain == o_rd_data[6:4]) else $error("lowrate");
    a_auto_enable: assert property (s_rd(8'h6C) |=>
        o_secondary_pd_gain.enable == $past(o_rd_data[7])) else $error("enable");
    a_gain_digital: assert property (i_req.addr == 8'h6C &&
        !i_req.wr_en && (!o_rd_data[7]
        || i_secondary_digital_fb) |=> o_secondary_pd_gain.gain ==
        $past(o_rd_data[2:0])) else $error("digital gain");
    a_gain_analog: assert property (i_req.addr == 8'h6C &&
        !i_req.wr_en && o_rd_data[7]
        && !i_secondary_digital_fb |=> o_secondary_pd_gain.gain ==
        $past(i_secondary_analog_gain)) else $error("analog gain");
    c_damp_max: cover property (o_primary_damping == 8'hC8);
    c_analog: cover property (o_secondary_pd_gain.enable &&
        !i_secondary_digital_fb);
    c_unmapped_wr: cover property (i_req.wr_en && i_req.addr == 8'h6D);
endmodule
bind loop_damping_gain_config loop_cfg_monitor u_loop_cfg_monitor (.i_ref_clk,
    .i_rst_b, .i_req, .o_rd_data, .i_primary_bw, .i_secondary_digital_fb,
    .i_secondary_analog_gain, .o_primary_damping, .o_primary_damping_ok,
    .o_primary_analog_lowrate_gain, .o_secondary_pd_gain);
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
`include "damp_ref.svh"
    logic                   i_ref_clk = 1'b0;
    logic                   i_rst_b = 1'b0;
    loop_cfg_pkg::reg_req_t i_req = '0;
    loop_cfg_pkg::loop_bw_t i_primary_bw = loop_cfg_pkg::BW_18HZ;
    logic                   i_primary_lowrate = 1'b1;
    logic                   i_secondary_digital_fb = 1'b1;
    logic [2:0]             i_secondary_analog_gain = 3'h3;
    logic [7:0]             o_rd_data, o_primary_damping, e;
    logic                   o_primary_damping_ok;
    logic [2:0]             o_primary_analog_lowrate_gain;
    loop_cfg_pkg::pd_gain_t o_secondary_pd_gain;
    int                     fails = 0, check_count = 0;
    always #2.5 i_ref_clk = ~i_ref_clk;
    loop_damping_gain_config u_loop_damping_gain_config (.i_ref_clk, .i_rst_b,
        .i_req, .o_rd_data, .i_primary_bw, .i_primary_lowrate,
        .i_secondary_digital_fb, .i_secondary_analog_gain, .o_primary_damping,
        .o_primary_damping_ok, .o_primary_analog_lowrate_gain,
        .o_secondary_pd_gain);
    task check(input string n, input logic [7:0] s, input logic [7:0] x);
        check_count++;
        if (s !== x)
        begin
            $display("[ERR] %s exp %h seen %h", n, x, s);
            fails++;
        end
    endtask
    // Returns once the decoded outputs have taken the write
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk) i_req <= '{1'b1, a, d};
        @(posedge i_ref_clk) i_req.wr_en <= 1'b0;
        @(posedge i_ref_clk) #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge i_ref_clk) i_req.addr <= a;
        #1 check("rd_data", o_rd_data, x);
    endtask
    task conclude;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        rd(8'h6B, 8'h14);
        rd(8'h6C, 8'hC2);
        rd(8'h3A, 8'h00);
        check("damp", o_primary_damping, 8'h32);
        check("low", 8'(o_primary_analog_lowrate_gain), 8'h01);
        $display("test reset done");
        for (int b = 0; b < 4; b++)
            for (int c = 0; c < 8; c++)
            begin
                @(posedge i_ref_clk)
                    i_primary_bw <= loop_cfg_pkg::loop_bw_t'(b);
                wr(8'h6B, 8'(c));
                e = damp(2'(b), 3'(c));
                check("damp", o_primary_damping, e);
                check("ok", 8'(o_primary_damping_ok), 8'(e != 8'h00));
            end
        $display("test damping done");
        wr(8'h6B, 8'hFF);
        rd(8'h6B, 8'h77);
        check("low", 8'(o_primary_analog_lowrate_gain), 8'h07);
        wr(8'h6D, 8'h00);
        rd(8'h6B, 8'h77);
        $display("test mask done");
        wr(8'h6C, 8'hFF);
        rd(8'h6C, 8'h87);
        check("pd", 8'(o_secondary_pd_gain), 8'h0F);
        @(posedge i_ref_clk) i_secondary_digital_fb <= 1'b0;
        @(posedge i_ref_clk) #1;
        check("pd", 8'(o_secondary_pd_gain), 8'h0B);
        wr(8'h6C, 8'h05);
        check("pd", 8'(o_secondary_pd_gain), 8'h05);
        $display("test gain done");
        conclude();
    end
    // About 150 cycles of tests; ten times that before giving up
    initial
    begin
        #7500;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
